//--- pkg/crs_consts.vh
/*
  Constants of the read-after-write stall sequencer: register indices,
  reset values, implemented-bit masks, instruction classes, state codes
  and cycle counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

// ==========================================================
// Register indices on the register port (word addresses)
`define CRS_IDX_WREG_LAST   5'h0F
`define CRS_IDX_STACK_LIMIT 5'h10
`define CRS_IDX_PC_LOW      5'h11
`define CRS_IDX_PC_HIGH     5'h12
`define CRS_IDX_TABLE_PAGE  5'h13
`define CRS_IDX_VIS_PAGE    5'h14
`define CRS_IDX_REPEAT_CNT  5'h15
`define CRS_IDX_STATUS      5'h16
`define CRS_IDX_CORE_CTRL   5'h17
`define CRS_IDX_IRQ_DIS_CNT 5'h18
`define CRS_IDX_STALL_CNT   5'h19

// ==========================================================
// Reset values
`define CRS_RST_ZERO        16'h0000
`define CRS_RST_STACK_PTR   16'h0800

// ==========================================================
// Implemented bits; unimplemented bits read zero
`define CRS_MASK_FULL       16'hFFFF
`define CRS_MASK_LOW_BYTE   16'h00FF
`define CRS_MASK_STATUS     16'h01FF
`define CRS_MASK_CORE_CTRL  16'h000C

// ==========================================================
// Field positions
`define CRS_CORE_CTRL_PSV   2
`define CRS_STACK_PTR_IDX   4'hF

// ==========================================================
// Executing instruction classes
`define CRS_CLS_NORMAL      3'h0
`define CRS_CLS_CALL        3'h1
`define CRS_CLS_RETURN      3'h2
`define CRS_CLS_LIT_RETURN  3'h3
`define CRS_CLS_JUMP        3'h4

// ==========================================================
// Sequencer states
`define CRS_ST_EXEC         2'h0
`define CRS_ST_STALL        2'h1
`define CRS_ST_PSV          2'h2

// ==========================================================
// Timing counts
`define CRS_PSV_EXTRA_CYC   2
`define CRS_Q_LAST          2'h3
`define CRS_Q1              2'h0
`define CRS_Q3              2'h2

`endif

//--- src/crs_stall_ctrl.v
/*
  Read-after-write stall sequencer and core register set of a 16-bit
  core. Orders stall, program-space and execution cycles of each
  instruction and drives the fetch, increment and latch strobes.
  Assumes the decoder feeds executing and prefetched instruction fields
  from logic on mclk, and that mclk carries four Q phases per
  instruction cycle.
*/
`timescale 1ns/100ps
`include "crs_consts.vh"

// Operation
// RULE_01 - Stall after call when next reads stack pointer
// RULE_02 - Returns never stall the next instruction
// RULE_03 - Literal return gets normal hazard check
// RULE_04 - Jumps and branches never stall
// RULE_05 - Repeat loop count unaffected by stalls
// RULE_06 - Repeat compares instruction against its own source
// RULE_07 - Visibility window access takes extra cycles
// RULE_08 - Stall first, then visibility, then execute
// RULE_09 - Stalled: opcode Q1 first, latch Q3 second
// RULE_10 - Reset values zero, stack pointer 0800
// RULE_11 - One cycle delay on address register hazard
// RULE_12 - Stall blocks addressing, increment and fetch
// RULE_13 - Compare destination with prefetch source every cycle
module crs_stall_ctrl #(
  parameter PSV_EXTRA = `CRS_PSV_EXTRA_CYC
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Register port
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Executing instruction
  input  wire        ex_valid,
  input  wire [2:0]  ex_class,
  input  wire [3:0]  ex_dest,
  input  wire        ex_we,
  input  wire        ex_modify,
  input  wire [3:0]  ex_src,
  // Prefetched instruction
  input  wire [3:0]  pf_src,
  input  wire        pf_ea_uses,
  input  wire        pf_ea_in_window,
  // Repeat loop
  input  wire        rep_active,
  // Pipeline strobes
  output reg         stall_cycle,
  output reg         psv_cycle,
  output reg         exec_cycle,
  output reg         pc_inc_en,
  output reg         fetch_en,
  output reg         ds_addr_en,
  output reg         ir_load,
  output reg         latch_load,
  output reg         psv_enable
);

  // ==========================================================
  // Core register set
  reg  [15:0] wreg [0:15];
  reg  [15:0] stack_limit;
  reg  [15:0] program_counter_low;
  reg  [15:0] program_counter_high;
  reg  [15:0] table_page_pointer;
  reg  [15:0] visibility_page_pointer;
  reg  [15:0] loop_repeat_counter;
  reg  [15:0] status_flags;
  reg  [15:0] core_control;
  reg  [15:0] irq_disable_counter;
  reg  [15:0] stall_count;

  // ==========================================================
  // Sequencer state
  reg  [1:0]  q;
  reg  [1:0]  state;
  reg  [1:0]  psv_left;
  reg  [1:0]  cyc_idx;
  reg         stalled;
  reg         psv_pend;
  reg  [1:0]  next_q;
  reg  [1:0]  next_state;
  reg  [1:0]  next_psv_left;
  reg  [1:0]  next_cyc_idx;
  reg         next_stalled;
  reg         next_psv_pend;

  wire        inst_end = (q == `CRS_Q_LAST);
  wire        psv_on   = core_control[`CRS_CORE_CTRL_PSV];
  // Loads one less than the run length; the count is cut to the counter width
  localparam integer PSV_LAST = PSV_EXTRA - 1;
  wire [1:0]  psv_init = PSV_LAST[1:0];

  // ==========================================================
  // Hazard detection
  reg  [3:0]  eff_dest;
  reg         eff_write;
  reg  [3:0]  cmp_src;
  reg         hazard;
  wire        psv_req  = psv_on & pf_ea_in_window;

  // Call, return and jump classes override the decoder's write indication
  always @* begin
    eff_dest  = ex_dest;
    eff_write = ex_we & ex_modify;
    case (ex_class)
      `CRS_CLS_CALL: begin
        eff_dest  = `CRS_STACK_PTR_IDX; // RULE_01
        eff_write = 1'b1;               // RULE_01
      end
      `CRS_CLS_RETURN: begin
        eff_write = 1'b0;               // RULE_02
      end
      `CRS_CLS_LIT_RETURN: begin
        eff_write = ex_we & ex_modify;  // RULE_03
      end
      `CRS_CLS_JUMP: begin
        eff_write = 1'b0;               // RULE_04
      end
      default: begin
        eff_write = ex_we & ex_modify;
      end
    endcase
    // Prefetch is frozen in a loop, so the instruction meets its own source
    cmp_src = rep_active ? ex_src : pf_src; // RULE_06
    // Only an address computed from the written register stalls
    hazard  = ex_valid & eff_write & pf_ea_uses & (eff_dest == cmp_src); // RULE_11 RULE_13
  end

  // ==========================================================
  // Next-state logic; Q phase advances each cycle, the rest only on the last Q phase
  always @* begin
    next_q        = q + 2'h1;
    next_state    = state;
    next_psv_left = psv_left;
    next_cyc_idx  = cyc_idx;
    next_stalled  = stalled;
    next_psv_pend = psv_pend;
    if (inst_end) begin
      next_cyc_idx = cyc_idx + 2'h1;
      case (state)
        `CRS_ST_EXEC: begin
          next_cyc_idx  = 2'h0;
          next_stalled  = hazard;
          next_psv_pend = psv_req;
          next_psv_left = psv_init;
          if (hazard) begin
            next_state = `CRS_ST_STALL;       // RULE_11
          end else if (psv_req) begin
            next_state = `CRS_ST_PSV;         // RULE_07
          end else begin
            next_state = `CRS_ST_EXEC;
          end
        end
        `CRS_ST_STALL: begin
          // The two cannot share a cycle; the stall always goes first
          if (psv_pend) begin
            next_state = `CRS_ST_PSV;         // RULE_08
          end else begin
            next_state = `CRS_ST_EXEC;
          end
        end
        `CRS_ST_PSV: begin
          if (psv_left == 2'h0) begin
            next_state = `CRS_ST_EXEC;        // RULE_08
          end else begin
            next_psv_left = psv_left - 2'h1;  // RULE_07
          end
        end
        default: begin
          next_state = `CRS_ST_EXEC;
        end
      endcase
    end
  end

  // ==========================================================
  // Sequencer registers and strobes, all from flip-flops
  always @(posedge mclk) begin
    if (rst) begin
      q           <= `CRS_Q1;
      state       <= `CRS_ST_EXEC;
      psv_left    <= 2'h0;
      cyc_idx     <= 2'h0;
      stalled     <= 1'b0;
      psv_pend    <= 1'b0;
      stall_cycle <= 1'b0;
      psv_cycle   <= 1'b0;
      exec_cycle  <= 1'b0;
      pc_inc_en   <= 1'b0;
      fetch_en    <= 1'b0;
      ds_addr_en  <= 1'b0;
      ir_load     <= 1'b0;
      latch_load  <= 1'b0;
      psv_enable  <= 1'b0;
    end else begin
      q           <= next_q;
      state       <= next_state;
      psv_left    <= next_psv_left;
      cyc_idx     <= next_cyc_idx;
      stalled     <= next_stalled;
      psv_pend    <= next_psv_pend;
      stall_cycle <= (next_state == `CRS_ST_STALL);
      psv_cycle   <= (next_state == `CRS_ST_PSV);
      exec_cycle  <= (next_state == `CRS_ST_EXEC);
      // Prior write still completes; only fetch, increment and addressing wait
      pc_inc_en   <= (next_state == `CRS_ST_EXEC);  // RULE_12
      fetch_en    <= (next_state == `CRS_ST_EXEC);  // RULE_12
      ds_addr_en  <= (next_state != `CRS_ST_STALL); // RULE_12
      ir_load     <= (next_q == `CRS_Q1) && (next_cyc_idx == 2'h0); // RULE_09
      latch_load  <= (next_q == `CRS_Q3) &&
                     (next_cyc_idx == {1'b0, next_stalled});        // RULE_09
      psv_enable  <= psv_on;
    end
  end

  // ==========================================================
  // Register writes; undefined-at-reset registers keep no reset
  integer i;
  always @(posedge mclk) begin
    if (rst) begin
      for (i = 0; i < 15; i = i + 1) begin
        wreg[i] <= `CRS_RST_ZERO;                 // RULE_10
      end
      wreg[15]                <= `CRS_RST_STACK_PTR; // RULE_10
      program_counter_low     <= `CRS_RST_ZERO;   // RULE_10
      program_counter_high    <= `CRS_RST_ZERO;   // RULE_10
      table_page_pointer      <= `CRS_RST_ZERO;   // RULE_10
      visibility_page_pointer <= `CRS_RST_ZERO;   // RULE_10
      status_flags            <= `CRS_RST_ZERO;   // RULE_10
      core_control            <= `CRS_RST_ZERO;   // RULE_10
      stall_count             <= `CRS_RST_ZERO;
    end else begin
      if (inst_end && (state == `CRS_ST_STALL)) begin
        stall_count <= stall_count + 16'h0001;
      end
      if (reg_wr) begin
        if (reg_addr <= `CRS_IDX_WREG_LAST) begin
          wreg[reg_addr[3:0]] <= reg_wdata;
        end
        case (reg_addr)
          `CRS_IDX_PC_LOW:    program_counter_low     <= reg_wdata;
          `CRS_IDX_PC_HIGH:   program_counter_high    <= reg_wdata & `CRS_MASK_LOW_BYTE;
          `CRS_IDX_TABLE_PAGE: table_page_pointer     <= reg_wdata & `CRS_MASK_LOW_BYTE;
          `CRS_IDX_VIS_PAGE:  visibility_page_pointer <= reg_wdata & `CRS_MASK_LOW_BYTE;
          `CRS_IDX_STATUS:    status_flags            <= reg_wdata & `CRS_MASK_STATUS;
          `CRS_IDX_CORE_CTRL: core_control            <= reg_wdata & `CRS_MASK_CORE_CTRL;
          default: begin
          end
        endcase
      end
    end
  end

  // Data registers left undefined by reset
  always @(posedge mclk) begin
    if (reg_wr && (reg_addr == `CRS_IDX_STACK_LIMIT)) begin
      stack_limit <= reg_wdata;
    end
    if (reg_wr && (reg_addr == `CRS_IDX_IRQ_DIS_CNT)) begin
      irq_disable_counter <= reg_wdata;
    end
    // Count moves only on execution cycles; a software write wins
    if (reg_wr && (reg_addr == `CRS_IDX_REPEAT_CNT)) begin
      loop_repeat_counter <= reg_wdata;
    end else if (inst_end && (state == `CRS_ST_EXEC) && rep_active &&
                 (loop_repeat_counter != 16'h0000)) begin
      loop_repeat_counter <= loop_repeat_counter - 16'h0001; // RULE_05
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the read strobe
  reg [15:0] rd_val;
  always @* begin
    rd_val = 16'h0000;
    if (reg_addr <= `CRS_IDX_WREG_LAST) begin
      rd_val = wreg[reg_addr[3:0]];
    end else begin
      case (reg_addr)
        `CRS_IDX_STACK_LIMIT: rd_val = stack_limit;
        `CRS_IDX_PC_LOW:      rd_val = program_counter_low;
        `CRS_IDX_PC_HIGH:     rd_val = program_counter_high;
        `CRS_IDX_TABLE_PAGE:  rd_val = table_page_pointer;
        `CRS_IDX_VIS_PAGE:    rd_val = visibility_page_pointer;
        `CRS_IDX_REPEAT_CNT:  rd_val = loop_repeat_counter;
        `CRS_IDX_STATUS:      rd_val = status_flags;
        `CRS_IDX_CORE_CTRL:   rd_val = core_control;
        `CRS_IDX_IRQ_DIS_CNT: rd_val = irq_disable_counter;
        `CRS_IDX_STALL_CNT:   rd_val = stall_count;
        default:              rd_val = 16'h0000; // Unmapped reads zero
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

//--- testbench/crs_stall_ctrl_chk.sv
/*
  Port checker of the stall sequencer: cycle kinds, their order and length,
  hazard decisions, latch strobes and masked register reads.
  Assumes a bind from the bench and crs_consts.vh on the include path.
*/
`timescale 1ns/100ps
`include "crs_consts.vh"

// ==========================================================
// Checker
module crs_stall_chk #(
  parameter PSV_EXTRA = `CRS_PSV_EXTRA_CYC
) (
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Register port
  input wire [4:0]  reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Instruction fields
  input wire        ex_valid,
  input wire [2:0]  ex_class,
  input wire [3:0]  ex_dest,
  input wire        ex_we,
  input wire        ex_modify,
  input wire [3:0]  ex_src,
  input wire [3:0]  pf_src,
  input wire        pf_ea_uses,
  input wire        pf_ea_in_window,
  input wire        rep_active,
  // Strobes
  input wire        stall_cycle,
  input wire        psv_cycle,
  input wire        exec_cycle,
  input wire        pc_inc_en,
  input wire        fetch_en,
  input wire        ds_addr_en,
  input wire        ir_load,
  input wire        latch_load,
  input wire        psv_enable
);
  // Hazard as seen at the decision edge; a call always writes the stack pointer
  wire [3:0] hz_dst = (ex_class == `CRS_CLS_CALL) ? `CRS_STACK_PTR_IDX : ex_dest;
  wire [3:0] hz_src = rep_active ? ex_src : pf_src;
  wire       hz_wr  = (ex_class == `CRS_CLS_CALL) | (ex_we & ex_modify);
  wire       hz     = ex_valid & hz_wr & pf_ea_uses & (hz_dst == hz_src) &
                      (ex_class != `CRS_CLS_RETURN) & (ex_class != `CRS_CLS_JUMP);
  wire       win    = pf_ea_uses & pf_ea_in_window & psv_enable;
  reg  [7:0] psv_run;

  // Length of the current run of visibility cycles
  always @(posedge mclk) begin
    if (rst || !psv_cycle)
      psv_run <= 8'h00;
    else
      psv_run <= psv_run + 8'h01;
  end

  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_one_kind;
    !$past(rst) |-> $onehot({stall_cycle, psv_cycle, exec_cycle});
  endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("cycle kind not one-hot");
  property p_stall_blk;
    stall_cycle |-> !pc_inc_en && !fetch_en && !ds_addr_en;
  endproperty
  a_stall_blk: assert property (p_stall_blk)
    else $error("fetch, increment or addressing during stall");
  property p_stall_len;
    $rose(stall_cycle) |-> stall_cycle[*4] ##1 !stall_cycle;
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("stall not one instruction cycle");
  property p_decide;
    exec_cycle ##1 ir_load |-> stall_cycle == $past(hz);
  endproperty
  a_decide: assert property (p_decide)
    else $error("stall decision wrong");
  property p_psv_go;
    (exec_cycle && !hz && win) ##1 ir_load |-> psv_cycle;
  endproperty
  a_psv_go: assert property (p_psv_go)
    else $error("window access without visibility cycle");
  property p_order;
    (exec_cycle && hz && win) ##1 ir_load |-> stall_cycle[*4] ##1 psv_cycle;
  endproperty
  a_order: assert property (p_order)
    else $error("stall and visibility out of order");
  property p_psv_len;
    $fell(psv_cycle) |-> exec_cycle && psv_run == 4 * PSV_EXTRA;
  endproperty
  a_psv_len: assert property (p_psv_len)
    else $error("visibility run length wrong");
  property p_ir_stall;
    $rose(stall_cycle) |-> ir_load ##1 (!latch_load)[*5] ##1 latch_load;
  endproperty
  a_ir_stall: assert property (p_ir_stall)
    else $error("latch strobes of stalled instruction wrong");
  property p_unimpl;
    $past(reg_rd) && $past(reg_addr) == `CRS_IDX_CORE_CTRL |->
      (reg_rdata & ~`CRS_MASK_CORE_CTRL) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented control bits read nonzero");
endmodule

//--- testbench/tb.sv
/*
  Bench of the stall sequencer: reset values, masked register access,
  directed hazard cases, random pipeline traffic, repeat counter.
  Assumes crs_consts.vh on the include path and the checker file.
*/
`timescale 1ns/100ps
`include "crs_consts.vh"

// ==========================================================
// Bench top
module tb;
  reg          mclk = 1'b0;
  reg          rst = 1'b1;
  reg  [4:0]   reg_addr = 5'h00;
  reg  [15:0]  reg_wdata = 16'h0000;
  reg          reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  reg          ex_valid = 1'b0, ex_we = 1'b0, ex_modify = 1'b0;
  reg  [2:0]   ex_class = 3'h0;
  reg  [3:0]   ex_dest = 4'h0, ex_src = 4'h0, pf_src = 4'h0;
  reg          pf_ea_uses = 1'b0, pf_ea_in_window = 1'b0, rep_active = 1'b0;
  reg  [31:0]  rv;
  wire [15:0]  reg_rdata;
  wire         stall_cycle, psv_cycle, exec_cycle, pc_inc_en, fetch_en;
  wire         ds_addr_en, ir_load, latch_load, psv_enable;
  integer      fail_count = 0, n_tests = 0, cyc = 0, i;
  logic [15:0] rd_q[$];
  logic [2:0]  kind_q[$];

  crs_stall_ctrl crs_stall_ctrl_inst (
    .mclk            (mclk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .ex_valid        (ex_valid),
    .ex_class        (ex_class),
    .ex_dest         (ex_dest),
    .ex_we           (ex_we),
    .ex_modify       (ex_modify),
    .ex_src          (ex_src),
    .pf_src          (pf_src),
    .pf_ea_uses      (pf_ea_uses),
    .pf_ea_in_window (pf_ea_in_window),
    .rep_active      (rep_active),
    .stall_cycle     (stall_cycle),
    .psv_cycle       (psv_cycle),
    .exec_cycle      (exec_cycle),
    .pc_inc_en       (pc_inc_en),
    .fetch_en        (fetch_en),
    .ds_addr_en      (ds_addr_en),
    .ir_load         (ir_load),
    .latch_load      (latch_load),
    .psv_enable      (psv_enable)
  );

  always #20 mclk = ~mclk;

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input [4:0] a, input [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Expected read data is queued as the strobe goes out
  task rd(input [4:0] a, input [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge mclk);
    reg_rd   <= 1'b0;
  endtask

  task wrrd(input [4:0] a, input [15:0] m);
    rv = $urandom;
    wr(a, rv[15:0]);
    rd(a, rv[15:0] & m);
  endtask

  // Inputs change at the start of the second phase, well before the decision edge
  task seq(input [2:0] c, input [3:0] d, input wm, input [3:0] s, input u,
           input w, input r, input [3:0] es, input [2:0] e);
    do @(negedge mclk); while (ir_load !== 1'b1);
    @(posedge mclk);
    ex_valid        <= 1'b1;
    ex_class        <= c;
    ex_dest         <= d;
    ex_we           <= wm;
    ex_modify       <= wm;
    ex_src          <= es;
    pf_src          <= s;
    pf_ea_uses      <= u;
    pf_ea_in_window <= w;
    rep_active      <= r;
    @(negedge mclk);
    kind_q.push_back(e);
  endtask

  // Read data one cycle after the strobe; cycle kind at each instruction start
  always @(posedge mclk) begin
    if (rd_d)
      chk(reg_rdata, rd_q.pop_front());
    if (ir_load === 1'b1 && kind_q.size() > 0)
      chk({13'h0000, stall_cycle, psv_cycle, exec_cycle}, {13'h0000, kind_q.pop_front()});
    rd_d <= reg_rd;
    cyc = cyc + 1;
    if (cyc > 10000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end

  initial begin
    rv = $urandom(77);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rd(i[4:0], (i == 15) ? `CRS_RST_STACK_PTR : `CRS_RST_ZERO);
    for (i = 17; i < 24; i = i + 1)
      if (i != 21) rd(i[4:0], `CRS_RST_ZERO);
    $display("test reset values done");
    wrrd(5'h03, `CRS_MASK_FULL);
    wrrd(`CRS_IDX_PC_HIGH, `CRS_MASK_LOW_BYTE);
    wrrd(`CRS_IDX_VIS_PAGE, `CRS_MASK_LOW_BYTE);
    wrrd(`CRS_IDX_STATUS, `CRS_MASK_STATUS);
    wrrd(`CRS_IDX_CORE_CTRL, `CRS_MASK_CORE_CTRL);
    wrrd(5'h1F, 16'h0000);
    $display("test register access done");
    wr(`CRS_IDX_CORE_CTRL, 16'h0004);
    seq(3'h0, 4'h2, 1, 4'h2, 1, 0, 0, 4'h0, 3'b100);
    seq(3'h0, 4'h2, 0, 4'h2, 1, 0, 0, 4'h0, 3'b001);
    seq(3'h1, 4'h0, 0, 4'hF, 1, 0, 0, 4'h0, 3'b100);
    seq(3'h2, 4'h2, 1, 4'h2, 1, 0, 0, 4'h0, 3'b001);
    seq(3'h3, 4'h2, 1, 4'h2, 1, 0, 0, 4'h0, 3'b100);
    seq(3'h4, 4'h2, 1, 4'h2, 1, 0, 0, 4'h0, 3'b001);
    seq(3'h0, 4'h5, 1, 4'h0, 1, 0, 1, 4'h5, 3'b100);
    seq(3'h0, 4'h5, 1, 4'h5, 1, 0, 1, 4'h0, 3'b001);
    seq(3'h0, 4'h2, 1, 4'h3, 1, 1, 0, 4'h0, 3'b010);
    seq(3'h0, 4'h2, 1, 4'h2, 1, 1, 0, 4'h0, 3'b100);
    seq(3'h0, 4'h2, 1, 4'h2, 0, 0, 0, 4'h0, 3'b001);
    while (kind_q.size() > 0) @(posedge mclk);
    $display("test hazard cases done");
    // Narrow index ranges make register matches, and so stalls, frequent
    repeat (1500) begin
      @(posedge mclk);
      rv = $urandom;
      ex_valid        <= rv[0] | rv[1];
      ex_class        <= (rv[4:2] > 3'h4) ? 3'h0 : rv[4:2];
      ex_dest         <= {rv[5], rv[5], rv[7:6]};
      ex_we           <= rv[8] | rv[9];
      ex_modify       <= rv[10] | rv[11];
      ex_src          <= {rv[12], rv[12], rv[14:13]};
      pf_src          <= {rv[15], rv[15], rv[17:16]};
      pf_ea_uses      <= rv[18] | rv[19];
      pf_ea_in_window <= rv[20];
      rep_active      <= rv[21] & rv[22];
    end
    $display("test random traffic done");
    wr(`CRS_IDX_REPEAT_CNT, 16'h0003);
    rep_active <= 1'b1;
    repeat (100) @(posedge mclk);
    rd(`CRS_IDX_REPEAT_CNT, 16'h0000);
    while (rd_q.size() > 0) @(posedge mclk);
    $display("test repeat count done");
    wrap_up;
  end
endmodule

bind crs_stall_ctrl crs_stall_chk #(.PSV_EXTRA(PSV_EXTRA)) crs_stall_chk_inst (.*);
